// >>> sector_flash_program_status_test.sv
`timescale 1ns/10ps
module sector_flash_program_status_test;
  localparam logic [7:0]  MAN_ID = 8'h3C;  // Arbitrary value
  localparam logic [7:0]  DEV_ID = 8'h5A;  // Arbitrary value
  localparam logic [14:0] SEC_A  = 15'h0A40;
  localparam logic [14:0] SEC_B  = 15'h1380;
  logic        clock, reset, req_valid, wr_valid, wr_ready, busy, rd_valid, manuf_valid;
  logic        prog_ok, prog_timeout, chip_sel_n, out_en_n, write_n, data_oe_n;
  logic [1:0]  req_op;
  logic [14:0] req_addr, addr;
  logic [7:0]  wr_data, rd_data, manuf_code, device_code, data_out, data_in;
  logic [7:0]  rd_cap, m_cap, d_cap;
  logic [7:0]  pb [0:63];
  logic [7:0]  ref_mem [int];
  logic [31:0] seed;
  int          mismatches, tests_run;
  // Short counts keep the run small
  sfp_host #(.BLC_CYC(2000), .WC_CYC(200)) dut (
    .clock(clock), .reset(reset), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .manuf_valid(manuf_valid),
    .manuf_code(manuf_code), .device_code(device_code), .prog_ok(prog_ok),
    .prog_timeout(prog_timeout), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .write_n(write_n), .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in));
  sfp_flash_model #(.PROG_CYC(60), .BLC_CYC(2000), .MAN_CODE(MAN_ID), .DEV_CODE(DEV_ID)) flash (
    .clock(clock), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
    .addr(addr), .data_out(data_out), .data_in(data_in));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fill(input logic [14:0] base);
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      pb[i] = seed[7:0];
      ref_mem[base + i] = pb[i];
    end
  endtask
  // Bytes stop after stall accepted ones
  task automatic run(input logic [1:0] op, input logic [14:0] a, input int stall);
    int   bi;
    logic rdy;
    bi = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    wr_data   <= pb[0];
    wr_valid  <= op == 2'h1 && stall > 0;
    @(posedge clock);
    req_valid <= 1'b0;
    for (int n = 0; n < 20000; n++) begin
      @(negedge clock);
      rdy = wr_valid && wr_ready;
      if (rd_valid) rd_cap = rd_data;
      if (manuf_valid) m_cap = manuf_code;
      if (manuf_valid) d_cap = device_code;
      if (!busy) return;
      @(posedge clock);
      if (rdy) begin
        bi++;
        wr_data  <= pb[bi[5:0]];
        wr_valid <= bi < 64 && bi < stall;
      end
    end
    mismatches++;
    final_report();
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 15'h0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    seed = 32'hCD96;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    run(2'h0, SEC_A, 0);
    check(rd_cap, 8'hFF);
    run(2'h2, 15'h0, 0);
    check(m_cap, MAN_ID);
    check(d_cap, DEV_ID);
    $display("test ident done");
    for (int t = 0; t < 2; t++) begin
      fill(SEC_A);
      run(2'h1, SEC_A, 64);
      check({6'h0, prog_timeout, prog_ok}, 8'h01);
      for (int i = 0; i < 64; i += 21) begin
        run(2'h0, SEC_A + 15'(i), 0);
        check(rd_cap, ref_mem[SEC_A + i]);
      end
      $display("test program %0d done", t);
    end
    fill(SEC_B);
    run(2'h1, SEC_B, 10);
    check({6'h0, prog_timeout, prog_ok}, 8'h02);
    repeat (2200) @(posedge clock);
    run(2'h0, SEC_B, 0);
    check(rd_cap, ref_mem[SEC_B]);
    run(2'h0, SEC_B + 15'd63, 0);
    check(rd_cap, 8'hxx);
    $display("test stall done");
    final_report();
  end
endmodule // sector_flash_program_status_test

// >>> sfp_bus_cycle.sv
`timescale 1ns/10ps
module sfp_bus_cycle (
  input  wire logic                       clock,
  input  wire logic                       reset,
  sfp_strobe_if.cycle                     cyc,
  output      logic                       chip_sel_n,
  output      logic                       out_en_n,
  output      logic                       write_n,
  output      logic [sfp_pkg::ADDR_W-1:0] addr,
  output      logic [sfp_pkg::DATA_W-1:0] data_out,
  output      logic                       data_oe_n,
  input  wire logic [sfp_pkg::DATA_W-1:0] data_in
);
  // ----------------------------------------------------------------------
  // One strobe: idle, active, recovery
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SFP_BC_IDLE = 3'b001,
    SFP_BC_ACT  = 3'b010,
    SFP_BC_REC  = 3'b100
  } sfp_bc_e;
  localparam int ACT_CYC = (sfp_pkg::WP_CYC > sfp_pkg::ACC_CYC) ? sfp_pkg::WP_CYC
                                                                : sfp_pkg::ACC_CYC;
  // Recovery also covers the minimum output-enable high pulse between polls
  localparam int REC_CYC = (sfp_pkg::WPH_CYC > sfp_pkg::OEHP_CYC) ? sfp_pkg::WPH_CYC
                                                                  : sfp_pkg::OEHP_CYC;
  sfp_bc_e    state;
  logic [3:0] cnt;
  logic       is_wr;

  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= SFP_BC_IDLE;
      cnt        <= 4'h0;
      is_wr      <= 1'b0;
      chip_sel_n <= 1'b1;
      out_en_n   <= 1'b1;
      write_n    <= 1'b1;
      addr       <= '0;
      data_out   <= '0;
      data_oe_n  <= 1'b1;
      cyc.done   <= 1'b0;
      cyc.rdata  <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (state)
        SFP_BC_IDLE: begin
          if (cyc.start) begin
            // OE stays high whenever WE and CE are both low
            addr       <= cyc.addr;
            data_out   <= cyc.wdata;
            is_wr      <= cyc.write;
            data_oe_n  <= ~cyc.write;
            chip_sel_n <= 1'b0;
            write_n    <= ~cyc.write;
            out_en_n   <= cyc.write;
            cnt        <= 4'(ACT_CYC - 1);
            state      <= SFP_BC_ACT;
          end
        end
        SFP_BC_ACT: begin
          if (cnt == 4'h0) begin
            if (!is_wr) begin
              cyc.rdata <= data_in;
            end
            chip_sel_n <= 1'b1;
            out_en_n   <= 1'b1;
            write_n    <= 1'b1;
            cnt        <= 4'(REC_CYC - 1);
            state      <= SFP_BC_REC;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        SFP_BC_REC: begin
          data_oe_n <= 1'b1;
          if (cnt == 4'h0) begin
            cyc.done <= 1'b1;
            state    <= SFP_BC_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: state <= SFP_BC_IDLE;
      endcase
    end
  end
  assign cyc.busy = (state != SFP_BC_IDLE);
endmodule // sfp_bus_cycle

// >>> sfp_flash_model.sv
`timescale 1ns/10ps
module sfp_flash_model #(
  parameter int         PROG_CYC = 60,
  parameter int         BLC_CYC  = 2000,
  parameter logic [7:0] MAN_CODE = 8'h3C,  // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5A   // Arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_n,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  data_out,
  output      logic [7:0]  data_in
);
  logic [7:0] mem [0:32767];
  logic [7:0] lat [0:63];
  bit         ld  [0:63];
  bit         arm, idm, tog, wq, oq;
  int         seq, nld, prg, idle;
  logic [8:0] secb;
  logic [7:0] last, hold;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
    idm  = 1'b0;
    tog  = 1'b1;
    hold = 8'h00;
  end
  // Strobes sampled mid-cycle, so pin changes never race the host's edge
  always @(negedge clock) begin
    if (!chip_sel_n && !out_en_n && oq) tog = !tog;
    if (!chip_sel_n && !out_en_n) hold = data_in;
    if (prg > 0) begin
      prg = prg - 1;
      if (prg == 0) begin
        for (int i = 0; i < 64; i++) mem[{secb, i[5:0]}] = ld[i] ? lat[i] : 8'hxx;
        arm = 1'b0;
      end
    end else if (nld > 0) begin
      idle = idle + 1;
      if (idle > BLC_CYC) prg = PROG_CYC;
      if (idle > BLC_CYC) nld = 0;
    end
    if (wq && !write_n && !chip_sel_n && prg == 0) begin
      if (arm) begin
        secb = addr[14:6];
        lat[addr[5:0]] = data_out;
        ld[addr[5:0]] = 1'b1;
        last = data_out;
        nld = nld + 1;
        idle = 0;
        if (nld == 64) prg = PROG_CYC;
        if (nld == 64) nld = 0;
      end else if (seq == 2 && addr == sfp_pkg::CMD_ADDR1) begin
        arm = data_out == sfp_pkg::CMD_PROT;
        if (data_out == sfp_pkg::CMD_IDIN) idm = 1'b1;
        if (data_out == sfp_pkg::CMD_IDOUT) idm = 1'b0;
        for (int i = 0; i < 64; i++) ld[i] = 1'b0;
        seq = 0;
      end else if (seq == 1 && addr == sfp_pkg::CMD_ADDR2 && data_out == sfp_pkg::CMD_D2) begin
        seq = 2;
      end else begin
        seq = (addr == sfp_pkg::CMD_ADDR1 && data_out == sfp_pkg::CMD_D1) ? 1 : 0;
      end
    end
    wq = write_n;
    oq = out_en_n;
  end
  // Released bus shows the inverse, so a stale sample never passes
  always_comb begin
    if (chip_sel_n || out_en_n) data_in = ~hold;
    else if (prg > 0) data_in = {~last[7], tog, last[5:0]};
    else if (idm) data_in = (addr[14:1] != 14'h0) ? ~hold : (addr[0] ? DEV_CODE : MAN_CODE);
    else data_in = mem[addr];
  end
endmodule // sfp_flash_model

// >>> sfp_host.sv
`timescale 1ns/10ps
module sfp_host #(
  parameter int BLC_CYC = sfp_pkg::BLC_CYC,
  parameter int WC_CYC  = sfp_pkg::WC_CYC
) (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       req_valid,
  input  wire logic [1:0]                 req_op,
  input  wire logic [sfp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [sfp_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_valid,
  output      logic                       wr_ready,
  output      logic                       busy,
  output      logic                       rd_valid,
  output      logic [sfp_pkg::DATA_W-1:0] rd_data,
  output      logic                       manuf_valid,
  output      logic [sfp_pkg::DATA_W-1:0] manuf_code,
  output      logic [sfp_pkg::DATA_W-1:0] device_code,
  output      logic                       prog_ok,
  output      logic                       prog_timeout,
  output      logic                       chip_sel_n,
  output      logic                       out_en_n,
  output      logic                       write_n,
  output      logic [sfp_pkg::ADDR_W-1:0] addr,
  output      logic [sfp_pkg::DATA_W-1:0] data_out,
  output      logic                       data_oe_n,
  input  wire logic [sfp_pkg::DATA_W-1:0] data_in
);
  // Counters are CNT_W bits wide; the byte window keeps a 400-cycle margin
  if (BLC_CYC < 400 || BLC_CYC >= (1 << sfp_pkg::CNT_W) || WC_CYC < 1
      || WC_CYC >= (1 << sfp_pkg::CNT_W)) begin : g_bad_timing
    $error("sfp_host: timing parameters out of range");
  end
  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    SFP_IDLE   = 7'b0000001,
    SFP_CMD    = 7'b0000010,
    SFP_LOAD   = 7'b0000100,
    SFP_POLL   = 7'b0001000,
    SFP_READ   = 7'b0010000,
    SFP_IDRD   = 7'b0100000,
    SFP_WAIT   = 7'b1000000
  } sfp_state_e;

  sfp_strobe_if cyc ();
  sfp_bus_cycle u_cycle (
    .clock      (clock),
    .reset      (reset),
    .cyc        (cyc),
    .chip_sel_n (chip_sel_n),
    .out_en_n   (out_en_n),
    .write_n    (write_n),
    .addr       (addr),
    .data_out   (data_out),
    .data_oe_n  (data_oe_n),
    .data_in    (data_in)
  );

  sfp_state_e                   state;
  sfp_state_e                   after_cmd;
  logic [1:0]                   op;
  logic [1:0]                   cmd_step;
  logic                         exit_pass;
  logic [sfp_pkg::ADDR_W-1:0]   base;
  logic [5:0]                   byte_idx;
  logic [sfp_pkg::DATA_W-1:0]   last_byte;
  logic [sfp_pkg::DATA_W-1:0]   prev_stat;
  logic                         have_prev;
  logic [sfp_pkg::CNT_W-1:0]    wc_cnt;
  logic                         issued;
  logic                         started;

  // ----------------------------------------------------------------------
  // Command sequence words
  // ----------------------------------------------------------------------
  logic [sfp_pkg::ADDR_W-1:0] cmd_addr;
  logic [sfp_pkg::DATA_W-1:0] cmd_data;
  logic [sfp_pkg::DATA_W-1:0] cmd_last;
  always_comb begin
    cmd_last = sfp_pkg::CMD_PROT;
    if (op == sfp_pkg::SFP_OP_ID_READ) begin
      cmd_last = exit_pass ? sfp_pkg::CMD_IDOUT : sfp_pkg::CMD_IDIN;
    end
    case (cmd_step)
      2'h0: begin
        cmd_addr = sfp_pkg::CMD_ADDR1;
        cmd_data = sfp_pkg::CMD_D1;
      end
      2'h1: begin
        cmd_addr = sfp_pkg::CMD_ADDR2;
        cmd_data = sfp_pkg::CMD_D2;
      end
      default: begin
        cmd_addr = sfp_pkg::CMD_ADDR1;
        cmd_data = cmd_last;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Strobe requests
  // ----------------------------------------------------------------------
  always_comb begin
    cyc.start = 1'b0;
    cyc.write = 1'b0;
    cyc.addr  = '0;
    cyc.wdata = '0;
    if (!issued && !cyc.busy) begin
      case (state)
        SFP_CMD: begin
          cyc.start = 1'b1;
          cyc.write = 1'b1;
          cyc.addr  = cmd_addr;
          cyc.wdata = cmd_data;
        end
        SFP_LOAD: begin
          cyc.start = wr_valid && wr_ready;
          cyc.write = 1'b1;
          // Sector number held on upper bits for every load strobe
          cyc.addr  = {base[sfp_pkg::ADDR_W-1:sfp_pkg::SECTOR_LSB], byte_idx};
          cyc.wdata = wr_data;
        end
        SFP_POLL: begin
          cyc.start = 1'b1;
          // Last loaded byte's address, so the polling bit ends on true data
          cyc.addr  = {base[sfp_pkg::ADDR_W-1:sfp_pkg::SECTOR_LSB],
                       6'(sfp_pkg::SECTOR_BYTES - 1)};
        end
        SFP_READ: begin
          cyc.start = 1'b1;
          cyc.addr  = base;
        end
        SFP_IDRD: begin
          cyc.start = 1'b1;
          cyc.addr  = {{(sfp_pkg::ADDR_W-1){1'b0}}, started};
        end
        default: cyc.start = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state        <= SFP_IDLE;
      after_cmd    <= SFP_IDLE;
      op           <= 2'h0;
      cmd_step     <= 2'h0;
      exit_pass    <= 1'b0;
      base         <= '0;
      byte_idx     <= 6'h0;
      last_byte    <= '0;
      prev_stat    <= '0;
      have_prev    <= 1'b0;
      wc_cnt       <= '0;
      issued       <= 1'b0;
      started      <= 1'b0;
      wr_ready     <= 1'b0;
      busy         <= 1'b0;
      rd_valid     <= 1'b0;
      rd_data      <= '0;
      manuf_valid  <= 1'b0;
      manuf_code   <= '0;
      device_code  <= '0;
      prog_ok      <= 1'b0;
      prog_timeout <= 1'b0;
    end else begin
      rd_valid    <= 1'b0;
      manuf_valid <= 1'b0;
      wr_ready    <= 1'b0;
      if (cyc.start) begin
        issued <= 1'b1;
      end
      if (cyc.done) begin
        issued <= 1'b0;
      end
      case (state)
        SFP_IDLE: begin
          busy <= 1'b0;
          if (req_valid) begin
            busy      <= 1'b1;
            op        <= req_op;
            base      <= req_addr;
            cmd_step  <= 2'h0;
            exit_pass <= 1'b0;
            byte_idx  <= 6'h0;
            started   <= 1'b0;
            prog_ok   <= 1'b0;
            prog_timeout <= 1'b0;
            case (req_op)
              sfp_pkg::SFP_OP_PROGRAM: begin
                // Protection restored by the device after every cycle
                state     <= SFP_CMD;
                after_cmd <= SFP_LOAD;
              end
              sfp_pkg::SFP_OP_ID_READ: begin
                state     <= SFP_CMD;
                after_cmd <= SFP_IDRD;
              end
              default: state <= SFP_READ;
            endcase
          end
        end
        SFP_CMD: begin
          if (cyc.done) begin
            cmd_step <= cmd_step + 2'h1;
            if (cmd_step == 2'h2) begin
              cmd_step <= 2'h0;
              state    <= after_cmd;
              wc_cnt   <= '0;
              wr_ready <= (after_cmd == SFP_LOAD);
            end
          end
        end
        SFP_LOAD: begin
          wc_cnt <= wc_cnt + 1'b1;
          if (cyc.start) begin
            last_byte <= wr_data;
          end
          if (cyc.done) begin
            wc_cnt   <= '0;
            byte_idx <= byte_idx + 6'h1;
            // Polling starts only after the whole sector is loaded; no partial programming offered
            if (byte_idx == 6'(sfp_pkg::SECTOR_BYTES - 1)) begin
              state     <= SFP_POLL;
              have_prev <= 1'b0;
            end else begin
              wr_ready <= 1'b1;
            end
          end else if (!issued && !cyc.busy && !cyc.start) begin
            wr_ready <= 1'b1;
          end
          // Source too slow: window lost, sector contents cannot be trusted
          if (!issued && wc_cnt >= sfp_pkg::CNT_W'(BLC_CYC - 400)) begin
            wr_ready     <= 1'b0;
            prog_timeout <= 1'b1;
            state        <= SFP_IDLE;
          end
        end
        SFP_POLL: begin
          wc_cnt <= wc_cnt + 1'b1;
          if (cyc.done) begin
            prev_stat <= cyc.rdata;
            have_prev <= 1'b1;
            // Toggle compared between reads, never against a level
            if (have_prev
                && cyc.rdata[sfp_pkg::TOGGLE_BIT] == prev_stat[sfp_pkg::TOGGLE_BIT]
                && cyc.rdata[sfp_pkg::POLL_BIT] == last_byte[sfp_pkg::POLL_BIT]) begin
              prog_ok <= 1'b1;
              state   <= SFP_IDLE;
            end else if (wc_cnt >= sfp_pkg::CNT_W'(WC_CYC)) begin
              prog_timeout <= 1'b1;
              state        <= SFP_IDLE;
            end
          end
        end
        SFP_READ: begin
          if (cyc.done) begin
            rd_data  <= cyc.rdata;
            rd_valid <= 1'b1;
            state    <= SFP_IDLE;
          end
        end
        SFP_IDRD: begin
          if (cyc.done) begin
            started <= 1'b1;
            if (!started) begin
              manuf_code <= cyc.rdata;
            end else begin
              device_code <= cyc.rdata;
              manuf_valid <= 1'b1;
              exit_pass   <= 1'b1;
              after_cmd   <= SFP_WAIT;
              state       <= SFP_CMD;
            end
          end
        end
        SFP_WAIT: begin
          // Exit sequence sent; normal array mode again (also after power loss)
          state <= SFP_IDLE;
        end
        default: state <= SFP_IDLE;
      endcase
    end
  end
endmodule // sfp_host

// >>> sfp_host_sva.sv
`timescale 1ns/10ps
module sfp_host_sva #(
  parameter int BLC_CYC = sfp_pkg::BLC_CYC
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire logic [1:0]  req_op,
  input wire logic [14:0] req_addr,
  input wire logic        busy,
  input wire logic        rd_valid,
  input wire logic        manuf_valid,
  input wire logic        prog_ok,
  input wire logic        prog_timeout,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        write_n,
  input wire logic [14:0] addr,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n,
  input wire logic [7:0]  data_in
);
  // --------------------------------------------------------------
  // Helper state
  // --------------------------------------------------------------
  logic        prog, armed, seen, wq, oq;
  logic [8:0]  sec;
  logic [6:0]  nld;
  logic [15:0] gap;
  logic [14:0] paddr;
  logic [7:0]  lastb, rdl;
  logic [22:0] h1, h2;
  wire take  = req_valid && !busy;
  wire wfall = wq && !write_n && !chip_sel_n;
  wire load  = wfall && armed;
  wire poll  = prog && nld == 7'd64;
  wire ofall = oq && !out_en_n && !chip_sel_n;
  always_ff @(posedge clock) begin
    wq <= write_n;
    oq <= out_en_n;
    if (!chip_sel_n && !out_en_n) rdl <= data_in;
    if (wfall) h1 <= {addr, data_out};
    if (wfall) h2 <= h1;
    if (load) lastb <= data_out;
  end
  always_ff @(posedge clock) begin
    if (load) gap <= 16'h0;
    else if (gap != 16'hFFFF) gap <= gap + 16'h1;
  end
  always_ff @(posedge clock) begin
    if (reset || take) begin
      prog  <= !reset && req_op == 2'h1;
      sec   <= req_addr[14:6];
      armed <= 1'b0;
      nld   <= 7'h0;
      seen  <= 1'b0;
    end else begin
      if (wfall && prog && addr == sfp_pkg::CMD_ADDR1 && data_out == sfp_pkg::CMD_PROT)
        armed <= 1'b1;
      if (load) nld <= nld + 7'h1;
      if (poll && ofall) paddr <= addr;
      if (poll && ofall) seen <= 1'b1;
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_idle_after_reset: assert property ($fell(reset) |-> chip_sel_n && write_n && out_en_n)
    else $error("strobes not idle after reset");
  a_read_answer: assert property (take && req_op == 2'h0 |-> ##[10:20] rd_valid)
    else $error("read answer missing");
  a_sector_bits: assert property (load |-> addr[14:6] == sec)
    else $error("sector bits wrong on byte load");
  a_full_sector: assert property ($rose(prog_ok) |-> nld == 7'd64)
    else $error("program finished without 64 loads");
  a_byte_window: assert property (load && nld != 7'h0 |-> gap < BLC_CYC)
    else $error("byte load window exceeded");
  a_poll_addr: assert property (poll && ofall && seen |-> addr == paddr)
    else $error("status address moved");
  a_code_order: assert property (wfall && prog && !armed && addr == sfp_pkg::CMD_ADDR1
    && data_out == sfp_pkg::CMD_PROT |-> h1 == {sfp_pkg::CMD_ADDR2, sfp_pkg::CMD_D2}
    && h2 == {sfp_pkg::CMD_ADDR1, sfp_pkg::CMD_D1})
    else $error("protect code sequence wrong");
  a_done_true_data: assert property ($rose(prog_ok) |-> rdl[7] == lastb[7])
    else $error("done without true data");
  a_drive_dir: assert property (!chip_sel_n |-> data_oe_n == write_n && out_en_n == !write_n)
    else $error("data direction or strobes wrong in a cycle");
  a_no_write_poll: assert property (poll |-> !wfall)
    else $error("write during program cycle");
  c_prog: cover property ($rose(prog_ok));
  c_abort: cover property ($rose(prog_timeout));
  c_ident: cover property (manuf_valid);
  c_poll: cover property (poll && ofall && seen);
endmodule // sfp_host_sva

bind sfp_host sfp_host_sva #(.BLC_CYC(BLC_CYC)) chk (
  .clock(clock), .reset(reset), .req_valid(req_valid), .req_op(req_op),
  .req_addr(req_addr), .busy(busy), .rd_valid(rd_valid), .manuf_valid(manuf_valid),
  .prog_ok(prog_ok), .prog_timeout(prog_timeout), .chip_sel_n(chip_sel_n),
  .out_en_n(out_en_n), .write_n(write_n), .addr(addr), .data_out(data_out),
  .data_oe_n(data_oe_n), .data_in(data_in)
);

// >>> sfp_pkg.sv
// Summary of operation
// - Sector number sits on upper address bits at every load strobe after protect code.
// - Host loads all 64 bytes of a sector on every reprogram; a stalled source ends the load early with prog_timeout.
// - Each byte load starts within 150 us of the previous one.
// - Status polling reads the last loaded byte's address, held constant for the whole cycle.
// - Command data and addresses are hexadecimal, bit seven and bit fourteen first.
package sfp_pkg;
  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W         = 15;
  localparam int DATA_W         = 8;
  localparam int SECTOR_BYTES   = 64;
  localparam int SECTOR_LSB     = 6;
  localparam int POLL_BIT       = 7;
  localparam int TOGGLE_BIT     = 6;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 25;
  localparam int CLK_NS         = 40;
  localparam int BLC_US         = 150;
  localparam int BLC_CYC        = (BLC_US * 1000) / CLK_NS;
  localparam int WP_NS          = 200;
  localparam int WP_CYC         = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_NS         = 200;
  localparam int WPH_CYC        = (WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_NS         = 250;
  localparam int ACC_CYC        = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEHP_NS        = 150;
  localparam int OEHP_CYC       = (OEHP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WC_MS          = 20;
  localparam int WC_CYC         = WC_MS * 1000 * CLK_MHZ;
  localparam int CNT_W          = 20;
  // ----------------------------------------------------------------------
  // Command codes and addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMD_ADDR1 = 15'h5555;
  localparam logic [ADDR_W-1:0] CMD_ADDR2 = 15'h2AAA;
  localparam logic [DATA_W-1:0] CMD_D1    = 8'hAA;
  localparam logic [DATA_W-1:0] CMD_D2    = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROT  = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_IDIN  = 8'h90;
  localparam logic [DATA_W-1:0] CMD_IDOUT = 8'hF0;
  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SFP_OP_READ    = 2'h0,
    SFP_OP_PROGRAM = 2'h1,
    SFP_OP_ID_READ = 2'h2
  } sfp_op_e;
endpackage

// >>> sfp_strobe_if.sv
`timescale 1ns/10ps
interface sfp_strobe_if;
  logic                           start;
  logic                           write;
  logic [sfp_pkg::ADDR_W-1:0]     addr;
  logic [sfp_pkg::DATA_W-1:0]     wdata;
  logic                           busy;
  logic                           done;
  logic [sfp_pkg::DATA_W-1:0]     rdata;
  modport master (output start, output write, output addr, output wdata,
                  input busy, input done, input rdata);
  modport cycle  (input start, input write, input addr, input wdata,
                  output busy, output done, output rdata);
endinterface
